/* File: btc_exec.v */
// execution unit for bit-test skip, indirect call, clear and complement instructions
// How it works
// - skip_if_bit_low with tested bit zero discards next instruction; two cycles total.
// - skip_if_bit_high with tested bit one discards next instruction; two cycles total.
// - indirect_subroutine_call pushes program counter plus one onto stack top.
// - call loads pc from pointer low three bits and working register; two cycles.
// - wipe_working_register clears working register and sets zero flag, one cycle.
// - wipe_file_location clears addressed file byte and sets zero flag, one cycle.
// - invert_file_location inverts the file byte, updates zero flag, one cycle.
// - destination bit zero writes working register, one writes file byte back.
`timescale 1ns/100ps
`default_nettype none
`include "btc_map.vh"
module btc_exec #(
	parameter STACK_LOG2 = 3,
	parameter FILE_WORDS = 128
) (
	input wire SYS_CLK_I, // 20 MHz core clock
	input wire RST_N_I, // synchronous reset, active low
	input wire PSEL_I, // apb select
	input wire PENABLE_I, // apb access phase
	input wire PWRITE_I, // apb direction, high = write
	input wire [7:0] PADDR_I, // apb byte address
	input wire [31:0] PWDATA_I, // apb write data
	output reg [31:0] PRDATA_O, // apb read data, registered
	output wire PREADY_O, // apb ready
	output wire PSLVERR_O // apb error on unmapped address
);
	localparam ST_IDLE = 2'b01;
	localparam ST_CALL2 = 2'b10;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg hold_q;
	reg [7:0] wreg_q;
	reg zero_q;
	reg skip_q;
	reg [10:0] pc_q;
	reg [7:0] table_high_pointer_q;
	reg [6:0] faddr_q;
	reg [31:0] cycles_q;
	reg [7:0] file_mem [0:FILE_WORDS-1];
	wire [STACK_LOG2-1:0] sp;
	wire [10:0] tos;
	wire access = PSEL_I & PENABLE_I;
	wire addr_ok;
	wire done = access & PREADY_O;
	wire wr_go = done & PWRITE_I;
	wire cmd_go = wr_go & (PADDR_I == `BTC_OFF_CMD);
	wire [2:0] op = PWDATA_I[`BTC_CMD_OP_MSB:`BTC_CMD_OP_LSB];
	wire [2:0] bsel = PWDATA_I[`BTC_CMD_BIT_MSB:`BTC_CMD_BIT_LSB];
	wire [6:0] raddr = PWDATA_I[`BTC_CMD_ADDR_MSB:`BTC_CMD_ADDR_LSB];
	wire dest = PWDATA_I[`BTC_CMD_DEST];
	wire [7:0] rval = file_mem[raddr];
	wire [7:0] inv = ~rval;
	wire tbit = rval[bsel];
	// a command that lands while a skip is pending is the discarded prefetch
	wire live = cmd_go & ~skip_q;
	wire call_go = live & (op == `BTC_OP_CALL);
	reg [31:0] rd_mux;

	// registers cover the mapped words only; everything else answers with an error
	assign addr_ok = (PADDR_I == `BTC_OFF_CMD) | (PADDR_I == `BTC_OFF_WREG) |
		(PADDR_I == `BTC_OFF_STATUS) | (PADDR_I == `BTC_OFF_PC) |
		(PADDR_I == `BTC_OFF_TABLE_HIGH_POINTER) | (PADDR_I == `BTC_OFF_SP) |
		(PADDR_I == `BTC_OFF_FADDR) | (PADDR_I == `BTC_OFF_FDATA) |
		(PADDR_I == `BTC_OFF_CYCLES) | (PADDR_I == `BTC_OFF_TOS);
	// ready waits out the call's second cycle plus one so read data is fresh
	assign PREADY_O = access & (state_q == ST_IDLE) & ~hold_q;
	assign PSLVERR_O = PREADY_O & ~addr_ok;

	btc_stack #(
		.DEPTH_LOG2(STACK_LOG2),
		.WIDTH(11)
	) u_stack (
		.clk_i(SYS_CLK_I),
		.rst_n_i(RST_N_I),
		.push_i(call_go),
		.data_i(pc_q + `BTC_ONE_PC),
		.sp_o(sp),
		.tos_o(tos)
	);

	// read decode
	always @* begin
		rd_mux = `BTC_RST_WORD;
		if (PADDR_I == `BTC_OFF_WREG) begin
			rd_mux[7:0] = wreg_q;
		end else if (PADDR_I == `BTC_OFF_STATUS) begin
			rd_mux[`BTC_ST_ZERO] = zero_q;
			rd_mux[`BTC_ST_SKIP] = skip_q;
			rd_mux[`BTC_ST_BUSY] = (state_q != ST_IDLE);
		end else if (PADDR_I == `BTC_OFF_PC) begin
			rd_mux[10:0] = pc_q;
		end else if (PADDR_I == `BTC_OFF_TABLE_HIGH_POINTER) begin
			rd_mux[7:0] = table_high_pointer_q;
		end else if (PADDR_I == `BTC_OFF_SP) begin
			rd_mux[STACK_LOG2-1:0] = sp;
		end else if (PADDR_I == `BTC_OFF_FADDR) begin
			rd_mux[6:0] = faddr_q;
		end else if (PADDR_I == `BTC_OFF_FDATA) begin
			rd_mux[7:0] = file_mem[faddr_q];
		end else if (PADDR_I == `BTC_OFF_CYCLES) begin
			rd_mux = cycles_q;
		end else if (PADDR_I == `BTC_OFF_TOS) begin
			rd_mux[10:0] = tos;
		end else begin
			rd_mux = `BTC_RST_WORD;
		end
	end

	// sequencer: only the call needs a second cycle
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (call_go) begin
					state_d = ST_CALL2;
				end
			end
			ST_CALL2: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// control and architectural state
	always @(posedge SYS_CLK_I) begin
		if (!RST_N_I) begin
			state_q <= ST_IDLE;
			hold_q <= 1'b0;
			wreg_q <= `BTC_RST_BYTE;
			zero_q <= 1'b0;
			skip_q <= 1'b0;
			pc_q <= `BTC_RST_PC;
			table_high_pointer_q <= `BTC_RST_BYTE;
			faddr_q <= `BTC_RST_FADDR;
			cycles_q <= `BTC_RST_WORD;
			PRDATA_O <= `BTC_RST_WORD;
		end else begin
			state_q <= state_d;
			hold_q <= (state_q == ST_CALL2);
			// sampled every cycle of a transfer except the completing one, which clears it, so the answer is a flop
			if (PSEL_I) begin
				PRDATA_O <= done ? `BTC_RST_WORD : rd_mux;
			end
			if (state_q == ST_CALL2) begin
				cycles_q <= cycles_q + `BTC_ONE_CYC;
				pc_q <= {table_high_pointer_q[`BTC_TABLE_HIGH_POINTER_MSB:0], wreg_q};
			end
			if (cmd_go) begin
				cycles_q <= cycles_q + `BTC_ONE_CYC;
				if (skip_q) begin
					// prefetched instruction replaced by a no-operation
					skip_q <= 1'b0;
					pc_q <= pc_q + `BTC_ONE_PC;
				end else begin
					if (op != `BTC_OP_CALL) begin
						pc_q <= pc_q + `BTC_ONE_PC;
					end
					case (op)
						`BTC_OP_SKIP_LOW: begin
							skip_q <= ~tbit;
						end
						`BTC_OP_SKIP_HIGH: begin
							skip_q <= tbit;
						end
						`BTC_OP_WIPE_WREG: begin
							wreg_q <= `BTC_RST_BYTE;
							zero_q <= 1'b1;
						end
						`BTC_OP_WIPE_FILE: begin
							zero_q <= 1'b1;
						end
						`BTC_OP_INVERT: begin
							zero_q <= (inv == `BTC_RST_BYTE);
							if (dest == `BTC_DEST_WREG) begin
								wreg_q <= inv;
							end
						end
						default: begin
							skip_q <= 1'b0;
						end
					endcase
				end
			end else if (wr_go) begin
				if (PADDR_I == `BTC_OFF_WREG) begin
					wreg_q <= PWDATA_I[7:0];
				end else if (PADDR_I == `BTC_OFF_STATUS) begin
					zero_q <= PWDATA_I[`BTC_ST_ZERO];
				end else if (PADDR_I == `BTC_OFF_PC) begin
					pc_q <= PWDATA_I[10:0];
				end else if (PADDR_I == `BTC_OFF_TABLE_HIGH_POINTER) begin
					table_high_pointer_q <= PWDATA_I[7:0];
				end else if (PADDR_I == `BTC_OFF_FADDR) begin
					faddr_q <= PWDATA_I[6:0];
				end
			end
		end
	end

	// file storage is data, left unreset; one writer for both paths
	always @(posedge SYS_CLK_I) begin
		if (live && (op == `BTC_OP_WIPE_FILE)) begin
			file_mem[raddr] <= `BTC_RST_BYTE;
		end else if (live && (op == `BTC_OP_INVERT) && (dest != `BTC_DEST_WREG)) begin
			file_mem[raddr] <= inv;
		end else if (wr_go && (PADDR_I == `BTC_OFF_FDATA)) begin
			file_mem[faddr_q] <= PWDATA_I[7:0];
		end
	end
endmodule
`default_nettype wire

/* File: btc_exec_assertions.sv */
// checker on the bus ports of the execution unit
`timescale 1ns/100ps
`default_nettype none
module btc_chk (
	input wire logic SYS_CLK_I, // core clock
	input wire logic RST_N_I, // reset, active low
	input wire logic PSEL_I, // select
	input wire logic PENABLE_I, // access phase
	input wire logic PWRITE_I, // direction
	input wire logic [7:0] PADDR_I, // byte address
	input wire logic [31:0] PWDATA_I, // write data
	input wire logic [31:0] PRDATA_O, // read data
	input wire logic PREADY_O, // ready
	input wire logic PSLVERR_O // error
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// access, completed transfer, completed command write
	wire acc = PSEL_I && PENABLE_I;
	wire done = acc && PREADY_O;
	wire cmd_w = done && PWRITE_I && PADDR_I == 8'h00;
	wire call_w = cmd_w && PWDATA_I[2:0] == 3'h3;
	a_ready_in_access: assert property (PREADY_O |-> acc) else $error("ready outside access");
	a_err_with_ready: assert property (PSLVERR_O |-> PREADY_O) else $error("error without ready");
	a_err_unmapped: assert property (done && PADDR_I > 8'h24 |-> PSLVERR_O) else $error("unmapped not flagged");
	a_err_mapped: assert property (done && PADDR_I <= 8'h24 && PADDR_I[1:0] == 2'h0 |-> !PSLVERR_O)
		else $error("mapped flagged");
	a_err_reads_zero: assert property (done && !PWRITE_I && PSLVERR_O |-> PRDATA_O == 32'h0)
		else $error("unmapped read not zero");
	a_call_two_cyc: assert property (call_w |=> !PREADY_O [*2]) else $error("call too short");
	a_call_resume: assert property (call_w ##3 acc |-> PREADY_O) else $error("call too long");
	// a plain command must not stall the bus like a call does
	a_single_cycle: assert property (cmd_w && PWDATA_I[2:0] != 3'h3 ##2 acc |-> PREADY_O)
		else $error("single cycle stalled");
	cover property (call_w);
	cover property (cmd_w && PWDATA_I[2:0] == 3'h1);
	cover property (done && PSLVERR_O);
endmodule
`default_nettype wire

/* File: btc_map.vh */
// register offsets, command fields, opcodes and reset values of the bit test/call/clear unit
`ifndef BTC_MAP_VH
`define BTC_MAP_VH
`define BTC_OFF_CMD 8'h00
`define BTC_OFF_WREG 8'h04
`define BTC_OFF_STATUS 8'h08
`define BTC_OFF_PC 8'h0C
`define BTC_OFF_TABLE_HIGH_POINTER 8'h10
`define BTC_OFF_SP 8'h14
`define BTC_OFF_FADDR 8'h18
`define BTC_OFF_FDATA 8'h1C
`define BTC_OFF_CYCLES 8'h20
`define BTC_OFF_TOS 8'h24
`define BTC_CMD_OP_LSB 0
`define BTC_CMD_OP_MSB 2
`define BTC_CMD_BIT_LSB 3
`define BTC_CMD_BIT_MSB 5
`define BTC_CMD_ADDR_LSB 6
`define BTC_CMD_ADDR_MSB 12
`define BTC_CMD_DEST 13
`define BTC_OP_NOP 3'h0
`define BTC_OP_SKIP_LOW 3'h1
`define BTC_OP_SKIP_HIGH 3'h2
`define BTC_OP_CALL 3'h3
`define BTC_OP_WIPE_WREG 3'h4
`define BTC_OP_WIPE_FILE 3'h5
`define BTC_OP_INVERT 3'h6
`define BTC_ST_ZERO 0
`define BTC_ST_SKIP 1
`define BTC_ST_BUSY 2
`define BTC_DEST_WREG 1'h0
`define BTC_TABLE_HIGH_POINTER_MSB 2
`define BTC_RST_FADDR 7'h00
`define BTC_RST_BYTE 8'h00
`define BTC_RST_PC 11'h000
`define BTC_RST_WORD 32'h00000000
`define BTC_ONE_PC 11'h001
`define BTC_ONE_CYC 32'h00000001
`endif

/* File: btc_stack.v */
// hardware return stack: store at pointer, then advance pointer
`timescale 1ns/100ps
`default_nettype none
module btc_stack #(
	parameter DEPTH_LOG2 = 3,
	parameter WIDTH = 11
) (
	input wire clk_i, // core clock
	input wire rst_n_i, // synchronous reset, active low
	input wire push_i, // one-cycle push strobe
	input wire [WIDTH-1:0] data_i, // return address to store
	output wire [DEPTH_LOG2-1:0] sp_o, // current stack pointer
	output reg [WIDTH-1:0] tos_o // last value pushed
);
	reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];
	reg [DEPTH_LOG2-1:0] sp_q;
	reg [DEPTH_LOG2-1:0] sp_d;
	assign sp_o = sp_q;
	// pointer wraps silently; overflow is the program's problem, as in the core
	always @* begin
		sp_d = sp_q;
		if (push_i) begin
			sp_d = sp_q + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
		end
	end
	// entry written at the old pointer, pointer moves on the same edge
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			sp_q <= {DEPTH_LOG2{1'b0}};
			tos_o <= {WIDTH{1'b0}};
		end else begin
			sp_q <= sp_d;
			if (push_i) begin
				mem[sp_q] <= data_i;
				tos_o <= data_i;
			end
		end
	end
endmodule
`default_nettype wire

/* File: test_bit_test_call_clear_exec.sv */
// self-checking bench for the execution unit
`timescale 1ns/100ps
`default_nettype none
module test_bit_test_call_clear_exec;
	logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, er;
	logic [7:0] pa = 8'h00;
	logic [31:0] pwd = 32'h0, q;
	wire [31:0] prd;
	wire prdy, perr;
	int fail_count = 0, tests_run = 0, cyc = 0, ws = 0;
	always #25 clk = ~clk;
	btc_exec u_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(pa), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr));
	task final_report;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// setup at once, access held until ready; back to back so a call's stall shows as wait states
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		ws = 0;
		while (prdy !== 1'b1) begin
			ws++;
			@(posedge clk);
		end
		q = prd;
		er = perr;
		pen <= 1'b0;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	function automatic logic [31:0] cmd(input logic [2:0] op, input logic [2:0] b, input logic [6:0] a, input logic d);
		return {18'h0, d, a, b, op};
	endfunction
	// hang guard, far above the hundred or so cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			final_report;
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdchk(8'h14, 32'h0);
		// file byte 5 = 5A: bit 2 clear, bit 3 set
		xfer(1'b1, 8'h18, 32'h5);
		xfer(1'b1, 8'h1C, 32'h5A);
		xfer(1'b1, 8'h04, 32'h55);
		xfer(1'b1, 8'h00, cmd(3'h1, 3'h2, 7'h05, 1'b0));
		rdchk(8'h08, 32'h2);
		xfer(1'b1, 8'h00, cmd(3'h4, 3'h0, 7'h00, 1'b0));
		rdchk(8'h04, 32'h55);
		rdchk(8'h0C, 32'h2);
		rdchk(8'h20, 32'h2);
		xfer(1'b1, 8'h00, cmd(3'h2, 3'h3, 7'h05, 1'b0));
		xfer(1'b1, 8'h00, cmd(3'h4, 3'h0, 7'h00, 1'b0));
		rdchk(8'h04, 32'h55);
		xfer(1'b1, 8'h00, cmd(3'h2, 3'h2, 7'h05, 1'b0));
		rdchk(8'h08, 32'h0);
		xfer(1'b1, 8'h00, cmd(3'h4, 3'h0, 7'h00, 1'b0));
		rdchk(8'h04, 32'h0);
		chk(ws, 32'h0);
		rdchk(8'h08, 32'h1);
		rdchk(8'h20, 32'h6);
		// clear the top file address
		xfer(1'b1, 8'h08, 32'h0);
		xfer(1'b1, 8'h18, 32'h7F);
		xfer(1'b1, 8'h1C, 32'h33);
		xfer(1'b1, 8'h00, cmd(3'h5, 3'h0, 7'h7F, 1'b0));
		rdchk(8'h1C, 32'h0);
		rdchk(8'h08, 32'h1);
		// invert back into the file, then into the working register
		xfer(1'b1, 8'h18, 32'h5);
		xfer(1'b1, 8'h1C, 32'hA6);
		xfer(1'b1, 8'h00, cmd(3'h6, 3'h0, 7'h05, 1'b1));
		rdchk(8'h1C, 32'h59);
		rdchk(8'h08, 32'h0);
		xfer(1'b1, 8'h1C, 32'hFF);
		xfer(1'b1, 8'h04, 32'h12);
		xfer(1'b1, 8'h00, cmd(3'h6, 3'h0, 7'h05, 1'b0));
		rdchk(8'h04, 32'h0);
		rdchk(8'h1C, 32'hFF);
		rdchk(8'h08, 32'h1);
		// two calls back to back; pointer bits above 2 must be ignored
		xfer(1'b1, 8'h0C, 32'hA0);
		xfer(1'b1, 8'h10, 32'hFA);
		xfer(1'b1, 8'h04, 32'h34);
		xfer(1'b1, 8'h00, cmd(3'h3, 3'h0, 7'h00, 1'b0));
		rdchk(8'h24, 32'hA1);
		chk(ws, 32'h1);
		xfer(1'b1, 8'h00, cmd(3'h3, 3'h0, 7'h00, 1'b0));
		rdchk(8'h0C, 32'h234);
		rdchk(8'h24, 32'h235);
		xfer(1'b1, 8'h14, 32'h7);
		rdchk(8'h14, 32'h2);
		rdchk(8'h20, 32'hD);
		xfer(1'b0, 8'h40, 32'h0);
		psel <= 1'b0;
		chk({31'h0, er}, 32'h1);
		chk(q, 32'h0);
		final_report;
	end
endmodule
bind btc_exec btc_chk u_chk (.SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
	.PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
	.PSLVERR_O(PSLVERR_O));
`default_nettype wire
